// ===== adtc_map.vh
// Function
// - Trigger code 00 external pin edge, 01 timer compare 0, 10 timer compare 1.
// - Channel select and trigger source are byte or bit accessible, reset zero.
// - Codes 0 to 11 pick one input, or scan from input 0 upward.
// - Result registers are read-only, word view and high byte alias.
// - Word view holds the ten result bits on top, low six bits zero.
// - High byte alias returns the upper eight bits of the result.
// - Software avoids result access on slow clocks; result reads ack after one wait state and cannot hang.
// - Compare enable bit turns threshold comparison off at 0, on at 1.
// - Condition 0 fires on high byte at or above threshold, 1 below it.
// - Select mode compare stores and interrupts on a hit, else stores to channel 0.
// - Scan mode compares channel 0 only, keeps scanning, no end-of-scan interrupt.
// - Compare mode register holds only bits 7 and 6, reads others as zero, byte or bit accessible, reset zero.
// - A control register write while enabled aborts and restarts conversion; in hardware trigger mode the code waits for the next trigger instead.
// - Threshold register is eight bits, byte or bit accessible, reset zero.
`ifndef ADTC_MAP_VH
`define ADTC_MAP_VH

`define ADTC_IDX_MODE0 32'hFFFFF200
`define ADTC_IDX_CHSEL 32'hFFFFF202
`define ADTC_IDX_TRIG 32'hFFFFF203
`define ADTC_IDX_PFM 32'hFFFFF204
`define ADTC_IDX_PFT 32'hFFFFF205
`define ADTC_IDX_STAT 32'hFFFFF206
`define ADTC_IDX_MASK 32'hFFFFF207
`define ADTC_IDX_RES_WORD 32'hFFFFF210
`define ADTC_IDX_RES_HIGH 32'hFFFFF220

`define ADTC_M0_CE 7
`define ADTC_M0_BUSY 6
`define ADTC_M0_HWTRIG 2
`define ADTC_M0_SCAN 1
`define ADTC_M0_CONT 0
`define ADTC_PFM_EN 7
`define ADTC_PFM_COND 6
`define ADTC_ST_END 0

`define ADTC_TRIG_EXT 2'h0
`define ADTC_TRIG_CC0 2'h1
`define ADTC_TRIG_CC1 2'h2

`define ADTC_NUM_CH 12
`define ADTC_LAST_CH 4'hB
`define ADTC_RST_BYTE 8'h00
`define ADTC_RST_RES 10'h000

`endif

// ===== adtc_trig_sel.v
`timescale 1ns/100ps
`default_nettype none
`include "adtc_map.vh"
module adtc_trig_sel (
  input wire clk_i,
  input wire rstn_i,
  input wire ext_pin_i,
  input wire cc0_i,
  input wire cc1_i,
  input wire [1:0] sel_i,
  output reg trig_o
);
  reg sync1_q;
  reg sync2_q;
  reg prev_q;

  // The pin is asynchronous; only the second stage feeds the edge detector.
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= ext_pin_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always @* begin
    case (sel_i)
      `ADTC_TRIG_EXT: trig_o = sync2_q & ~prev_q;
      `ADTC_TRIG_CC0: trig_o = cc0_i;
      `ADTC_TRIG_CC1: trig_o = cc1_i;
      default: trig_o = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ===== adtc_results.v
`timescale 1ns/100ps
`default_nettype none
`include "adtc_map.vh"
module adtc_results (
  input wire clk_i,
  input wire rstn_i,
  input wire we_i,
  input wire [3:0] widx_i,
  input wire [9:0] wdata_i,
  input wire [3:0] ridx_i,
  output wire [15:0] word_o,
  output wire [7:0] high_o
);
  reg [9:0] res_q [0:`ADTC_NUM_CH-1];
  wire [9:0] rd;

  genvar g;
  generate
    for (g = 0; g < `ADTC_NUM_CH; g = g + 1) begin : g_ch
      localparam [3:0] CH_IDX = g;
      always @(posedge clk_i) begin
        if (!rstn_i) begin
          res_q[g] <= `ADTC_RST_RES;
        end else if (we_i && widx_i == CH_IDX) begin
          res_q[g] <= wdata_i;
        end
      end
    end
  endgenerate

  assign rd = (ridx_i <= `ADTC_LAST_CH) ? res_q[ridx_i] : `ADTC_RST_RES;
  assign word_o = {rd, 6'h00};
  assign high_o = rd[9:2];
endmodule
`default_nettype wire

// ===== adtc_ctrl.v
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "adtc_map.vh"
module adtc_ctrl (
  input wire CLOCK_I,
  input wire RESETN_I,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [31:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output wire [31:0] DAT_O,
  output wire ACK_O,
  output wire IRQ_O,
  input wire EXT_TRIG_I,
  input wire TMR_CC0_I,
  input wire TMR_CC1_I,
  output wire CONV_START_O,
  output wire [3:0] CONV_CH_O,
  input wire CONV_DONE_I,
  input wire [9:0] CONV_DATA_I
);
  localparam S_IDLE = 2'h0;
  localparam S_WAIT = 2'h1;
  localparam S_START = 2'h2;
  localparam S_CONV = 2'h3;

  reg ack_q;
  reg [31:0] dat_q;
  reg [7:0] mode0_q;
  reg [1:0] trig_q;
  reg [3:0] chsel_q;
  reg [1:0] pfm_q;
  reg [7:0] pft_q;
  reg stat_q;
  reg mask_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] ch_q;
  reg [3:0] ch_d;
  reg start_q;
  reg start_d;
  reg restart_q;
  reg res_we;
  reg [3:0] res_idx;
  reg end_evt;
  reg [31:0] rd_d;

  wire wb_req;
  wire acc;
  wire wr;
  wire cfg_wr;
  wire hw_trig;
  wire ce;
  wire hw;
  wire scan;
  wire cont;
  wire pf_en;
  wire pf_cond;
  wire busy;
  wire ge;
  wire hit;
  wire last;
  wire [15:0] res_word;
  wire [7:0] res_high;
  wire [3:0] ridx;
  wire in_word;
  wire in_high;
  wire stat_rd;

  function reg_hit;
    input [31:0] adr;
    input [31:0] idx;
    begin
      reg_hit = (adr[31:2] == idx[29:0]);
    end
  endfunction

  function in_bank;
    input [31:0] adr;
    input [31:0] base;
    begin
      in_bank = (adr[31:6] == base[29:4]) && (adr[5:2] <= `ADTC_LAST_CH);
    end
  endfunction

  // Wishbone classic: one wait state, ack for one cycle, then dropped.
  // Result reads are answered like any other register, so no wait can hang.
  assign wb_req = CYC_I & STB_I;
  assign acc = wb_req & ack_q;
  assign wr = acc & WE_I & SEL_I[0];
  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

  always @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req & ~ack_q;
    end
  end

  assign cfg_wr = wr & (reg_hit(ADR_I, `ADTC_IDX_MODE0) |
                        reg_hit(ADR_I, `ADTC_IDX_TRIG) |
                        reg_hit(ADR_I, `ADTC_IDX_CHSEL) |
                        reg_hit(ADR_I, `ADTC_IDX_PFM) |
                        reg_hit(ADR_I, `ADTC_IDX_PFT));

  always @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      mode0_q <= `ADTC_RST_BYTE;
      trig_q <= 2'h0;
      chsel_q <= 4'h0;
      pfm_q <= 2'h0;
      pft_q <= `ADTC_RST_BYTE;
      mask_q <= 1'b0;
    end else if (wr) begin
      if (reg_hit(ADR_I, `ADTC_IDX_MODE0)) begin
        mode0_q[`ADTC_M0_CE] <= DAT_I[`ADTC_M0_CE];
        mode0_q[`ADTC_M0_HWTRIG] <= DAT_I[`ADTC_M0_HWTRIG];
        mode0_q[`ADTC_M0_SCAN] <= DAT_I[`ADTC_M0_SCAN];
        mode0_q[`ADTC_M0_CONT] <= DAT_I[`ADTC_M0_CONT];
      end
      if (reg_hit(ADR_I, `ADTC_IDX_TRIG)) begin
        trig_q <= DAT_I[1:0];
      end
      if (reg_hit(ADR_I, `ADTC_IDX_CHSEL)) begin
        chsel_q <= DAT_I[3:0];
      end
      if (reg_hit(ADR_I, `ADTC_IDX_PFM)) begin
        pfm_q <= {DAT_I[`ADTC_PFM_EN], DAT_I[`ADTC_PFM_COND]};
      end
      if (reg_hit(ADR_I, `ADTC_IDX_PFT)) begin
        pft_q <= DAT_I[7:0];
      end
      if (reg_hit(ADR_I, `ADTC_IDX_MASK)) begin
        mask_q <= DAT_I[`ADTC_ST_END];
      end
    end
  end

  assign ce = mode0_q[`ADTC_M0_CE];
  assign hw = mode0_q[`ADTC_M0_HWTRIG];
  assign scan = mode0_q[`ADTC_M0_SCAN];
  assign cont = mode0_q[`ADTC_M0_CONT];
  assign pf_en = pfm_q[1];
  assign pf_cond = pfm_q[0];
  assign busy = (state_q == S_START) | (state_q == S_CONV);

  adtc_trig_sel u_trig (
    .clk_i(CLOCK_I),
    .rstn_i(RESETN_I),
    .ext_pin_i(EXT_TRIG_I),
    .cc0_i(TMR_CC0_I),
    .cc1_i(TMR_CC1_I),
    .sel_i(trig_q),
    .trig_o(hw_trig)
  );

  // The restart acts one cycle after the write so it sees the new settings.
  always @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= cfg_wr;
    end
  end

  assign ge = (CONV_DATA_I[9:2] >= pft_q);
  assign hit = pf_cond ? ~ge : ge;
  assign last = ~scan | (ch_q >= chsel_q) | (ch_q == `ADTC_LAST_CH);

  always @* begin
    state_d = state_q;
    ch_d = ch_q;
    start_d = 1'b0;
    res_we = 1'b0;
    res_idx = ch_q;
    end_evt = 1'b0;
    if (!ce) begin
      state_d = S_IDLE;
    end else if (restart_q) begin
      ch_d = scan ? 4'h0 : chsel_q;
      state_d = hw ? S_WAIT : S_START;
    end else if (hw && hw_trig && state_q != S_IDLE) begin
      ch_d = scan ? 4'h0 : chsel_q;
      state_d = S_START;
    end else begin
      case (state_q)
        S_START: begin
          start_d = 1'b1;
          state_d = S_CONV;
        end
        S_CONV: begin
          if (CONV_DONE_I) begin
            res_we = 1'b1;
            if (!scan) begin
              if (pf_en) begin
                res_idx = hit ? ch_q : 4'h0;
                end_evt = hit;
              end else begin
                end_evt = 1'b1;
              end
            end else if (pf_en) begin
              end_evt = (ch_q == 4'h0) & hit;
            end else begin
              end_evt = last;
            end
            if (!last) begin
              ch_d = ch_q + 4'h1;
              state_d = S_START;
            end else begin
              ch_d = scan ? 4'h0 : chsel_q;
              if (cont) begin
                state_d = S_START;
              end else if (hw) begin
                state_d = S_WAIT;
              end else begin
                state_d = S_IDLE;
              end
            end
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      state_q <= S_IDLE;
      ch_q <= 4'h0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ch_q <= ch_d;
      start_q <= start_d;
    end
  end

  assign CONV_START_O = start_q;
  assign CONV_CH_O = ch_q;

  adtc_results u_res (
    .clk_i(CLOCK_I),
    .rstn_i(RESETN_I),
    .we_i(res_we),
    .widx_i(res_idx),
    .wdata_i(CONV_DATA_I),
    .ridx_i(ridx),
    .word_o(res_word),
    .high_o(res_high)
  );

  assign ridx = ADR_I[5:2];
  assign in_word = in_bank(ADR_I, `ADTC_IDX_RES_WORD);
  assign in_high = in_bank(ADR_I, `ADTC_IDX_RES_HIGH);
  assign stat_rd = acc & ~WE_I & reg_hit(ADR_I, `ADTC_IDX_STAT);

  // A new event in the clearing read's cycle survives the clear.
  always @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      stat_q <= 1'b0;
    end else if (end_evt) begin
      stat_q <= 1'b1;
    end else if (stat_rd) begin
      stat_q <= 1'b0;
    end
  end

  assign IRQ_O = stat_q & mask_q;

  always @* begin
    rd_d = 32'h00000000;
    if (reg_hit(ADR_I, `ADTC_IDX_MODE0)) begin
      rd_d[7:0] = {ce, busy, 3'h0, hw, scan, cont};
    end else if (reg_hit(ADR_I, `ADTC_IDX_TRIG)) begin
      rd_d[1:0] = trig_q;
    end else if (reg_hit(ADR_I, `ADTC_IDX_CHSEL)) begin
      rd_d[3:0] = chsel_q;
    end else if (reg_hit(ADR_I, `ADTC_IDX_PFM)) begin
      rd_d[7:6] = pfm_q;
    end else if (reg_hit(ADR_I, `ADTC_IDX_PFT)) begin
      rd_d[7:0] = pft_q;
    end else if (reg_hit(ADR_I, `ADTC_IDX_STAT)) begin
      rd_d[`ADTC_ST_END] = stat_q;
    end else if (reg_hit(ADR_I, `ADTC_IDX_MASK)) begin
      rd_d[`ADTC_ST_END] = mask_q;
    end else if (in_word) begin
      rd_d[15:0] = res_word;
    end else if (in_high) begin
      rd_d[7:0] = res_high;
    end
  end

  always @(posedge CLOCK_I) begin
    if (!RESETN_I) begin
      dat_q <= 32'h00000000;
    end else if (wb_req && !ack_q) begin
      dat_q <= rd_d;
    end
  end
endmodule
`default_nettype wire

// ===== adtc_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "adtc_map.vh"
module adtc_chk (
  input wire CLOCK_I,
  input wire RESETN_I,
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [31:0] ADR_I,
  input wire [31:0] DAT_O,
  input wire ACK_O,
  input wire IRQ_O,
  input wire CONV_START_O,
  input wire [3:0] CONV_CH_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESETN_I);
  wire rd = ACK_O && !WE_I;
  wire [31:0] ow = ADR_I - (`ADTC_IDX_RES_WORD << 2);
  wire [31:0] oh = ADR_I - (`ADTC_IDX_RES_HIGH << 2);
  wire pfm = ADR_I == (`ADTC_IDX_PFM << 2);
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not answered in one cycle");
  chk_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  chk_start_pulse: assert property (CONV_START_O |=> !CONV_START_O)
    else $error("start pulse too long");
  chk_ch_legal: assert property (CONV_START_O |-> CONV_CH_O <= `ADTC_LAST_CH)
    else $error("start on prohibited channel");
  chk_word_view: assert property (rd && ow < 32'd48 |->
    DAT_O[5:0] == 6'h00 && DAT_O[31:16] == 16'h0000)
    else $error("result word layout wrong");
  chk_high_view: assert property (rd && oh < 32'd48 |->
    DAT_O[31:8] == 24'h000000)
    else $error("high byte view too wide");
  chk_pfm_bits: assert property (rd && pfm |->
    DAT_O[5:0] == 6'h00 && DAT_O[31:8] == 24'h000000)
    else $error("compare mode spare bits set");
  cover property (rd && ow < 32'd48);
  cover property (CONV_START_O);
  cover property ($rose(IRQ_O));
endmodule
bind adtc_ctrl adtc_chk adtc_chk_inst (.CLOCK_I(CLOCK_I),
  .RESETN_I(RESETN_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ_O(IRQ_O),
  .CONV_START_O(CONV_START_O), .CONV_CH_O(CONV_CH_O));
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "adtc_map.vh"
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'hF;
  logic ext = 1'b0;
  logic cc0 = 1'b0;
  logic cc1 = 1'b0;
  logic done = 1'b0;
  logic [9:0] cdat = 10'h000;
  wire [31:0] rdat;
  wire ack;
  wire irq;
  wire start;
  wire [3:0] ch;
  int fail_count = 0;
  int num_checks = 0;
  adtc_ctrl adtc_ctrl_inst (.CLOCK_I(clk), .RESETN_I(rstn), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
    .DAT_O(rdat), .ACK_O(ack), .IRQ_O(irq), .EXT_TRIG_I(ext),
    .TMR_CC0_I(cc0), .TMR_CC1_I(cc1), .CONV_START_O(start),
    .CONV_CH_O(ch), .CONV_DONE_I(done), .CONV_DATA_I(cdat));
  initial forever #25 clk = ~clk;
  task automatic check(input logic [31:0] seen, exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] i, d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= i << 2;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) fail_count++;
  endtask
  task automatic wr(input logic [31:0] i, d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [31:0] i, exp, input string nm);
    logic [31:0] q;
    bus(1'b0, i, 32'h0, q);
    check(q, exp, nm);
  endtask
  task automatic wait_start(input logic [3:0] c);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (start !== 1'b1 && n < 200);
    check({27'h0, start, ch}, {27'h0, 1'b1, c}, "start_ch");
  endtask
  task automatic conv(input logic [9:0] d);
    @(posedge clk);
    done <= 1'b1;
    cdat <= d;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic t_reset;
    rd(`ADTC_IDX_CHSEL, 32'h0, "chsel");
    rd(`ADTC_IDX_TRIG, 32'h0, "trig");
    rd(`ADTC_IDX_PFM, 32'h0, "pfm");
    rd(`ADTC_IDX_PFT, 32'h0, "pft");
    rd(32'hFFFFF2F0, 32'h0, "unmapped");
  endtask
  task automatic t_select;
    wr(`ADTC_IDX_MASK, 32'h1);
    wr(`ADTC_IDX_CHSEL, 32'h5);
    wr(`ADTC_IDX_MODE0, 32'h80);
    wait_start(4'h5);
    wr(`ADTC_IDX_PFT, 32'h0);
    wait_start(4'h5);
    conv(10'h2A5);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1, "irq_set");
    rd(`ADTC_IDX_RES_WORD + 5, 32'hA940, "word");
    rd(`ADTC_IDX_RES_HIGH + 5, 32'hA9, "high");
    wr(`ADTC_IDX_RES_WORD + 5, 32'hFFFF);
    rd(`ADTC_IDX_RES_WORD + 5, 32'hA940, "word_ro");
    rd(`ADTC_IDX_STAT, 32'h1, "stat");
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq_clr");
  endtask
  task automatic t_scan;
    wr(`ADTC_IDX_MODE0, 32'h0);
    wr(`ADTC_IDX_CHSEL, 32'h2);
    wr(`ADTC_IDX_MODE0, 32'h82);
    for (int c = 0; c < 3; c++) begin
      wait_start(c[3:0]);
      conv({c[3:0], 6'h15});
    end
    repeat (3) @(posedge clk);
    for (int c = 0; c < 3; c++) begin
      rd(`ADTC_IDX_RES_WORD + c, {c[3:0], 12'h540}, "scan");
    end
    rd(`ADTC_IDX_STAT, 32'h1, "scan_end");
  endtask
  task automatic t_compare;
    wr(`ADTC_IDX_MODE0, 32'h0);
    wr(`ADTC_IDX_CHSEL, 32'h3);
    wr(`ADTC_IDX_PFT, 32'h80);
    wr(`ADTC_IDX_PFM, 32'h80);
    wr(`ADTC_IDX_MODE0, 32'h80);
    wait_start(4'h3);
    conv(10'h100);
    repeat (3) @(posedge clk);
    rd(`ADTC_IDX_STAT, 32'h0, "miss");
    rd(`ADTC_IDX_RES_WORD, 32'h4000, "miss_ch0");
    wr(`ADTC_IDX_MODE0, 32'h0);
    wr(`ADTC_IDX_PFM, 32'hC0);
    wr(`ADTC_IDX_MODE0, 32'h80);
    wait_start(4'h3);
    conv(10'h104);
    repeat (3) @(posedge clk);
    rd(`ADTC_IDX_STAT, 32'h1, "hit");
    rd(`ADTC_IDX_RES_WORD + 3, 32'h4100, "hit_ch");
    rd(`ADTC_IDX_PFM, 32'hC0, "pfm_rb");
    wr(`ADTC_IDX_MODE0, 32'h0);
    wr(`ADTC_IDX_PFM, 32'h0);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    ext <= (k == 0);
    cc0 <= (k == 1);
    cc1 <= (k == 2);
    @(posedge clk);
    cc0 <= 1'b0;
    cc1 <= 1'b0;
    @(posedge clk);
    ext <= 1'b0;
  endtask
  task automatic t_hw;
    logic s;
    for (int k = 0; k < 3; k++) begin
      wr(`ADTC_IDX_MODE0, 32'h0);
      wr(`ADTC_IDX_TRIG, k);
      wr(`ADTC_IDX_MODE0, 32'h84);
      pulse((k + 1) % 3);
      s = 1'b0;
      repeat (8) begin
        @(posedge clk);
        if (start === 1'b1) s = 1'b1;
      end
      check({31'h0, s}, 32'h0, "wrong_src");
      pulse(k);
      wait_start(4'h3);
      conv(10'h0);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict;
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_select;
    t_scan;
    t_compare;
    t_hw;
    give_verdict;
  end
endmodule
`default_nettype wire
